// ==== verilog/boot_mode_strap_selector.sv ====
// boot mode strap selector: samples strap pins once per reset and decodes one boot action
// Notes on behaviour
// [R1] each reset, after init completes, sample straps and pick exactly one boot action
// [R2] variant A: top strap 1 jumps to flash entry, others ignored
// [R3] variant A: top 0, second 1 runs the SPI EEPROM loader
// [R4] variant A: pattern 0011 runs the loader from the first UART
// [R5] variant A: 0010 jumps to high RAM block, 0001 jumps to OTP
// [R6] variant A: 0000 runs the parallel loader from the second GPIO port
// [R7] variant A: pull-up on top strap only
// [R8] jumps to flash, RAM or OTP load no code, just branch
// [R9] variant B: 111 jumps to flash entry
// [R10] variant B: 110 loads from first UART, 101 from SPI EEPROM
// [R11] variant B: 100 loads from I2C EEPROM at address 0x50
// [R12] variant B: 011 runs CAN loader on mailbox 1
// [R13] variant B: 011 without CAN is reserved but still runs the CAN loader
// [R14] variant B: 010 jumps to low RAM block at 0, 001 jumps to OTP
// [R15] variant B: 000 runs the parallel loader on GPIO 0 to 15
// [R16] variant C: modes F to A pick flash, UART, SPI, I2C, CAN, buffered serial
// [R17] variant C: mode 9 jumps to external bus x16, mode 8 as x32
// [R18] variant C: 7 OTP, 6 GPIO loader, 5 external bus loader, 4 RAM
// [R19] variant C: mode 3 branches to the boot mode check routine
// [R20] variant C: modes 2, 1, 0 branch flash, RAM, UART skipping calibration
// [R21] variant C: all four straps pulled up, floating reads 1
// [R22] board ties straps to fixed levels or fits jumpers
// [R23] straps captured once per reset and held
// [R24] a static parameter selects the variant decode table
`timescale 1ns/1ps
`include "boot_strap_regs.svh"
module boot_mode_strap_selector
    import boot_strap_pkg::*;
#(
    parameter variant_t VARIANT = VAR_A,
    parameter bit HAS_CAN = 1'b1,
    parameter logic [21:0] C_FLASH_ENTRY = 22'h000000,
    parameter logic [21:0] C_RAM_ENTRY = 22'h000000,
    parameter logic [21:0] C_OTP_ENTRY = 22'h000000,
    parameter logic [21:0] C_EXT_ENTRY = 22'h000000
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic init_done_i,
    input wire logic [3:0] strap_pin_i,
    output logic [3:0] pullup_en_o,
    output logic [3:0] strap_seen_o,
    output logic boot_valid_o,
    output boot_sel_t boot_sel_o
);
    boot_state_t state_ff;
    logic [1:0] settle_cnt_ff;
    logic [3:0] strap_sync_w;
    logic [3:0] strap_ff;
    logic valid_ff;
    boot_sel_t sel_ff;
    logic [3:0] pu_ff;

    // pull-up mask is fixed per variant
    function automatic logic [3:0] pu_mask(input variant_t v);
        logic [3:0] m;
        m = `BOOT_PU_A; // R7
        if (v == VAR_B)
        begin
            m = `BOOT_PU_B;
        end
        else if (v == VAR_C)
        begin
            m = `BOOT_PU_C; // R21
        end
        return m;
    endfunction : pu_mask

    function automatic boot_sel_t jump_to(input boot_action_t a, input logic [21:0] addr);
        boot_sel_t r;
        r = '0;
        r.action = a;
        r.source = SRC_NONE;
        r.entry_addr = addr;
        r.loads_code = 1'b0; // R8
        return r;
    endfunction : jump_to

    function automatic boot_sel_t load_from(input boot_source_t s);
        boot_sel_t r;
        r = '0;
        r.action = ACT_LOAD;
        r.source = s;
        r.loads_code = 1'b1;
        if (s == SRC_I2C)
        begin
            r.i2c_addr = `BOOT_I2C_EEPROM_ADDR; // R11
        end
        if (s == SRC_CAN)
        begin
            r.can_mailbox = `BOOT_CAN_MAILBOX; // R12
        end
        return r;
    endfunction : load_from

    function automatic boot_sel_t decode_a(input logic [3:0] s);
        boot_sel_t r;
        r = jump_to(ACT_JUMP_FLASH, `BOOT_FLASH_ENTRY);
        if (s[`BOOT_A_TOP_BIT])
        begin
            r = jump_to(ACT_JUMP_FLASH, `BOOT_FLASH_ENTRY); // R2
        end
        else if (s[`BOOT_A_SECOND_BIT])
        begin
            r = load_from(SRC_SPI); // R3
        end
        else
        begin
            case (s[`BOOT_A_LOW_MSB:0])
                `BOOT_A_UART: r = load_from(SRC_UART); // R4
                `BOOT_A_RAM: r = jump_to(ACT_JUMP_RAM, `BOOT_A_RAM_ENTRY); // R5
                `BOOT_A_OTP: r = jump_to(ACT_JUMP_OTP, `BOOT_OTP_ENTRY); // R5
                default: r = load_from(SRC_PAR_GPIO); // R6
            endcase
        end
        return r;
    endfunction : decode_a

    function automatic boot_sel_t decode_b(input logic [2:0] s);
        boot_sel_t r;
        case (s)
            `BOOT_B_FLASH: r = jump_to(ACT_JUMP_FLASH, `BOOT_FLASH_ENTRY); // R9
            `BOOT_B_UART: r = load_from(SRC_UART); // R10
            `BOOT_B_SPI: r = load_from(SRC_SPI); // R10
            `BOOT_B_I2C: r = load_from(SRC_I2C); // R11
            `BOOT_B_CAN:
            begin
                // without the controller the loader still runs and waits forever
                r = load_from(SRC_CAN); // R12
                r.reserved_sel = !HAS_CAN; // R13
            end
            `BOOT_B_RAM: r = jump_to(ACT_JUMP_RAM, `BOOT_B_RAM_ENTRY); // R14
            `BOOT_B_OTP: r = jump_to(ACT_JUMP_OTP, `BOOT_OTP_ENTRY); // R14
            default: r = load_from(SRC_PAR_GPIO); // R15
        endcase
        return r;
    endfunction : decode_b

    function automatic boot_sel_t decode_c(input logic [3:0] s);
        boot_sel_t r;
        case (s)
            `BOOT_C_FLASH: r = jump_to(ACT_JUMP_FLASH, C_FLASH_ENTRY); // R16
            `BOOT_C_UART: r = load_from(SRC_UART); // R16
            `BOOT_C_SPI: r = load_from(SRC_SPI); // R16
            `BOOT_C_I2C: r = load_from(SRC_I2C); // R16
            `BOOT_C_CAN: r = load_from(SRC_CAN); // R16
            `BOOT_C_BSERIAL: r = load_from(SRC_BSERIAL); // R16
            `BOOT_C_EXT16: r = jump_to(ACT_JUMP_EXTBUS, C_EXT_ENTRY); // R17
            `BOOT_C_EXT32:
            begin
                r = jump_to(ACT_JUMP_EXTBUS, C_EXT_ENTRY); // R17
                r.bus_x32 = 1'b1; // R17
            end
            `BOOT_C_OTP: r = jump_to(ACT_JUMP_OTP, C_OTP_ENTRY); // R18
            `BOOT_C_PAR_GPIO: r = load_from(SRC_PAR_GPIO); // R18
            `BOOT_C_PAR_EXT: r = load_from(SRC_PAR_EXTBUS); // R18
            `BOOT_C_RAM: r = jump_to(ACT_JUMP_RAM, C_RAM_ENTRY); // R18
            `BOOT_C_CHECK: r = jump_to(ACT_CHECK_MODE, `BOOT_ADDR_ZERO); // R19
            `BOOT_C_FLASH_NOCAL:
            begin
                r = jump_to(ACT_JUMP_FLASH, C_FLASH_ENTRY); // R20
                r.skip_calib = 1'b1; // R20
            end
            `BOOT_C_RAM_NOCAL:
            begin
                r = jump_to(ACT_JUMP_RAM, C_RAM_ENTRY); // R20
                r.skip_calib = 1'b1; // R20
            end
            default:
            begin
                r = load_from(SRC_UART); // R20
                r.skip_calib = 1'b1; // R20
            end
        endcase
        return r;
    endfunction : decode_c

    // table chosen at elaboration; no run-time switching
    function automatic boot_sel_t decode_straps(input logic [3:0] s);
        boot_sel_t r;
        r = decode_a(s);
        if (VARIANT == VAR_B)
        begin
            r = decode_b(s[`BOOT_B_MSB:0]); // R24
        end
        else if (VARIANT == VAR_C)
        begin
            r = decode_c(s); // R24
        end
        return r;
    endfunction : decode_straps

    strap_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i(strap_pin_i),
        .q_o(strap_sync_w)
    );

    // sequencing: wait for init, let the synchroniser settle, capture, decode
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_ff <= ST_WAIT;
            settle_cnt_ff <= `BOOT_CNT_ZERO;
        end
        else
        begin
            case (state_ff)
                ST_WAIT:
                begin
                    if (init_done_i)
                    begin
                        state_ff <= ST_SETTLE; // R1
                        settle_cnt_ff <= `BOOT_CNT_ZERO;
                    end
                end
                ST_SETTLE:
                begin
                    if (settle_cnt_ff == `BOOT_SETTLE_CYC - `BOOT_CNT_ONE)
                    begin
                        state_ff <= ST_DECODE;
                    end
                    else
                    begin
                        settle_cnt_ff <= settle_cnt_ff + `BOOT_CNT_ONE;
                    end
                end
                ST_DECODE:
                begin
                    state_ff <= ST_DONE;
                end
                default:
                begin
                    state_ff <= ST_DONE;
                end
            endcase
        end
    end

    // one capture per reset; later toggling of shared pins is ignored
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            strap_ff <= 4'h0;
        end
        else if (state_ff == ST_SETTLE && settle_cnt_ff == `BOOT_SETTLE_CYC - `BOOT_CNT_ONE)
        begin
            strap_ff <= strap_sync_w; // R23
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sel_ff <= '0;
            valid_ff <= 1'b0;
        end
        else if (state_ff == ST_DECODE)
        begin
            sel_ff <= decode_straps(strap_ff); // R1
            valid_ff <= 1'b1;
        end
    end

    // mask is a constant of the variant, so reset needs no branch of its own
    always_ff @(posedge clk_i)
    begin
        pu_ff <= pu_mask(VARIANT); // R7 R21
    end

    assign pullup_en_o = pu_ff;
    assign strap_seen_o = strap_ff;
    assign boot_valid_o = valid_ff;
    assign boot_sel_o = sel_ff;

    property p_valid_timing;
        @(posedge clk_i) disable iff (srst_i)
        (state_ff == ST_WAIT && init_done_i) |-> !boot_valid_o [*4] ##1 boot_valid_o;
    endproperty
    a_valid_timing: assert property (p_valid_timing) else $error("boot not valid 4 after init"); // R1

    property p_one_action;
        @(posedge clk_i) disable iff (srst_i)
        boot_valid_o |-> boot_sel_o.action != ACT_NONE;
    endproperty
    a_one_action: assert property (p_one_action) else $error("valid boot without action"); // R1

    property p_held;
        @(posedge clk_i) disable iff (srst_i)
        boot_valid_o |=> boot_valid_o && $stable(strap_seen_o) && $stable(boot_sel_o);
    endproperty
    a_held: assert property (p_held) else $error("boot selection changed after capture"); // R23

    property p_a_flash;
        @(posedge clk_i) disable iff (srst_i)
        (VARIANT == VAR_A && boot_valid_o && strap_seen_o[`BOOT_A_TOP_BIT]) |->
            boot_sel_o.action == ACT_JUMP_FLASH && boot_sel_o.entry_addr == `BOOT_FLASH_ENTRY;
    endproperty
    a_a_flash: assert property (p_a_flash) else $error("variant A flash jump wrong"); // R2

    property p_a_spi;
        @(posedge clk_i) disable iff (srst_i)
        (VARIANT == VAR_A && boot_valid_o && strap_seen_o[3:2] == 2'h1) |->
            boot_sel_o.action == ACT_LOAD && boot_sel_o.source == SRC_SPI;
    endproperty
    a_a_spi: assert property (p_a_spi) else $error("variant A SPI loader wrong"); // R3

    property p_a_low;
        @(posedge clk_i) disable iff (srst_i)
        (VARIANT == VAR_A && boot_valid_o && strap_seen_o == 4'h2) |->
            boot_sel_o.action == ACT_JUMP_RAM && boot_sel_o.entry_addr == `BOOT_A_RAM_ENTRY;
    endproperty
    a_a_low: assert property (p_a_low) else $error("variant A RAM jump wrong"); // R5

    property p_no_load_on_jump;
        @(posedge clk_i) disable iff (srst_i)
        (boot_valid_o && boot_sel_o.action inside {ACT_JUMP_FLASH, ACT_JUMP_RAM, ACT_JUMP_OTP})
            |-> !boot_sel_o.loads_code && boot_sel_o.source == SRC_NONE;
    endproperty
    a_no_load_on_jump: assert property (p_no_load_on_jump) else $error("jump loads code"); // R8

    property p_b_i2c;
        @(posedge clk_i) disable iff (srst_i)
        (VARIANT == VAR_B && boot_valid_o && strap_seen_o[2:0] == `BOOT_B_I2C) |->
            boot_sel_o.source == SRC_I2C && boot_sel_o.i2c_addr == `BOOT_I2C_EEPROM_ADDR;
    endproperty
    a_b_i2c: assert property (p_b_i2c) else $error("variant B I2C loader wrong"); // R11

    property p_b_can;
        @(posedge clk_i) disable iff (srst_i)
        (VARIANT == VAR_B && boot_valid_o && strap_seen_o[2:0] == `BOOT_B_CAN) |->
            boot_sel_o.source == SRC_CAN && boot_sel_o.can_mailbox == `BOOT_CAN_MAILBOX
            && boot_sel_o.reserved_sel == !HAS_CAN;
    endproperty
    a_b_can: assert property (p_b_can) else $error("variant B CAN loader wrong"); // R13

    property p_c_nocal;
        @(posedge clk_i) disable iff (srst_i)
        (VARIANT == VAR_C && boot_valid_o) |->
            boot_sel_o.skip_calib == (strap_seen_o <= `BOOT_C_FLASH_NOCAL);
    endproperty
    a_c_nocal: assert property (p_c_nocal) else $error("variant C calibration skip wrong"); // R20

    property p_pullups;
        @(posedge clk_i) disable iff (srst_i)
        $past(srst_i) |-> pullup_en_o == ((VARIANT == VAR_C) ? `BOOT_PU_C :
            (VARIANT == VAR_A) ? `BOOT_PU_A : `BOOT_PU_B);
    endproperty
    a_pullups: assert property (p_pullups) else $error("pull-up mask wrong"); // R21

    c_flash: cover property (@(posedge clk_i) disable iff (srst_i)
        $rose(boot_valid_o) && boot_sel_o.action == ACT_JUMP_FLASH);
    c_loader: cover property (@(posedge clk_i) disable iff (srst_i)
        $rose(boot_valid_o) && boot_sel_o.loads_code);
    c_check: cover property (@(posedge clk_i) disable iff (srst_i)
        $rose(boot_valid_o) && boot_sel_o.action == ACT_CHECK_MODE);
endmodule : boot_mode_strap_selector

// ==== verilog/boot_strap_regs.svh ====
// constants for the boot mode strap selector: entry points, patterns, bit positions
`ifndef BOOT_STRAP_REGS_SVH
`define BOOT_STRAP_REGS_SVH

// entry addresses (22-bit program space)
`define BOOT_FLASH_ENTRY 22'h3F7FF6
`define BOOT_A_RAM_ENTRY 22'h3F8000
`define BOOT_OTP_ENTRY 22'h3D7800
`define BOOT_B_RAM_ENTRY 22'h000000
`define BOOT_ADDR_ZERO 22'h000000

// loader side constants
`define BOOT_I2C_EEPROM_ADDR 7'h50
`define BOOT_CAN_MAILBOX 5'h01

// strap bit positions inside the 4-bit strap vector
`define BOOT_A_TOP_BIT 3
`define BOOT_A_SECOND_BIT 2
`define BOOT_A_LOW_MSB 1
`define BOOT_B_MSB 2

// variant A low pair patterns, top and second both 0
`define BOOT_A_UART 2'h3
`define BOOT_A_RAM 2'h2
`define BOOT_A_OTP 2'h1
`define BOOT_A_PAR 2'h0

// variant B patterns, top-middle-bottom
`define BOOT_B_FLASH 3'h7
`define BOOT_B_UART 3'h6
`define BOOT_B_SPI 3'h5
`define BOOT_B_I2C 3'h4
`define BOOT_B_CAN 3'h3
`define BOOT_B_RAM 3'h2
`define BOOT_B_OTP 3'h1
`define BOOT_B_PAR 3'h0

// variant C hex modes
`define BOOT_C_FLASH 4'hF
`define BOOT_C_UART 4'hE
`define BOOT_C_SPI 4'hD
`define BOOT_C_I2C 4'hC
`define BOOT_C_CAN 4'hB
`define BOOT_C_BSERIAL 4'hA
`define BOOT_C_EXT16 4'h9
`define BOOT_C_EXT32 4'h8
`define BOOT_C_OTP 4'h7
`define BOOT_C_PAR_GPIO 4'h6
`define BOOT_C_PAR_EXT 4'h5
`define BOOT_C_RAM 4'h4
`define BOOT_C_CHECK 4'h3
`define BOOT_C_FLASH_NOCAL 4'h2
`define BOOT_C_RAM_NOCAL 4'h1
`define BOOT_C_UART_NOCAL 4'h0

// internal pull-up masks per variant
`define BOOT_PU_A 4'h8
`define BOOT_PU_B 4'h0
`define BOOT_PU_C 4'hF

// settle cycles after init so the synchroniser holds post-reset pin levels
`define BOOT_SETTLE_CYC 2'h2
`define BOOT_CNT_ONE 2'h1
`define BOOT_CNT_ZERO 2'h0

`endif

// ==== verilog/boot_strap_pkg.sv ====
// types shared by the boot mode strap selector
package boot_strap_pkg;

    typedef enum logic [1:0] {
        VAR_A = 2'h0,
        VAR_B = 2'h1,
        VAR_C = 2'h2
    } variant_t;

    typedef enum logic [2:0] {
        ACT_NONE = 3'h0,
        ACT_JUMP_FLASH = 3'h1,
        ACT_JUMP_RAM = 3'h2,
        ACT_JUMP_OTP = 3'h3,
        ACT_JUMP_EXTBUS = 3'h4,
        ACT_LOAD = 3'h5,
        ACT_CHECK_MODE = 3'h6
    } boot_action_t;

    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_UART = 3'h1,
        SRC_SPI = 3'h2,
        SRC_I2C = 3'h3,
        SRC_CAN = 3'h4,
        SRC_BSERIAL = 3'h5,
        SRC_PAR_GPIO = 3'h6,
        SRC_PAR_EXTBUS = 3'h7
    } boot_source_t;

    // gray along wait -> settle -> decode -> done
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_SETTLE = 2'b01,
        ST_DECODE = 2'b11,
        ST_DONE = 2'b10
    } boot_state_t;

    typedef struct packed {
        boot_action_t action;
        boot_source_t source;
        logic [21:0] entry_addr;
        logic loads_code;
        logic bus_x32;
        logic skip_calib;
        logic reserved_sel;
        logic [6:0] i2c_addr;
        logic [4:0] can_mailbox;
    } boot_sel_t;

endpackage : boot_strap_pkg

// ==== verilog/strap_sync.sv ====
// two-flop synchroniser for the strap pins
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule : strap_sync

// ==== tb/strap_board.sv ====
// board side of the strap pins: jumpers drive fixed levels or leave a pin floating
`timescale 1ns/1ps
module strap_board (
    input wire logic clk_i,
    input wire logic [3:0] level_i,
    input wire logic [3:0] float_i,
    input wire logic [3:0] pullup_en_i,
    output logic [3:0] pin_o
);
    logic toggle_ff;

    initial toggle_ff = 1'b0;

    // an unpulled floating pin is not allowed to settle to a friendly value
    always @(posedge clk_i)
    begin
        toggle_ff <= ~toggle_ff;
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (float_i[i])
                pin_o[i] = pullup_en_i[i] ? 1'b1 : toggle_ff;
            else
                pin_o[i] = level_i[i];
        end
    end
endmodule : strap_board

// ==== tb/tb.sv ====
// self-checking bench for the boot mode strap selector, all three variants side by side
`timescale 1ns/1ps
module tb;
    import boot_strap_pkg::*;
    localparam logic [21:0] CF = 22'h100000;
    localparam logic [21:0] CR = 22'h000400;
    localparam logic [21:0] CO = 22'h200000;
    localparam logic [21:0] CE = 22'h300000;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic init_done_i = 1'b0;
    logic [3:0] lvl = 4'h0;
    logic [3:0] flt = 4'h0;
    logic [3:0] pin_a, pin_b, pin_c, pu_a, pu_b, pu_c, seen_a, seen_b, seen_c;
    logic valid_a, valid_b, valid_c;
    boot_sel_t sel_a, sel_b, sel_c;
    int n_errors = 0;
    int tests_run = 0;

    initial forever #25 clk_i = ~clk_i;

    strap_board brd_a (.clk_i(clk_i), .level_i(lvl), .float_i(flt), .pullup_en_i(pu_a),
        .pin_o(pin_a));
    strap_board brd_b (.clk_i(clk_i), .level_i(lvl), .float_i(flt), .pullup_en_i(pu_b),
        .pin_o(pin_b));
    strap_board brd_c (.clk_i(clk_i), .level_i(lvl), .float_i(flt), .pullup_en_i(pu_c),
        .pin_o(pin_c));
    boot_mode_strap_selector #(.VARIANT(VAR_A)) uut_a (.clk_i(clk_i), .srst_i(srst_i),
        .init_done_i(init_done_i), .strap_pin_i(pin_a), .pullup_en_o(pu_a),
        .strap_seen_o(seen_a), .boot_valid_o(valid_a), .boot_sel_o(sel_a));
    // no CAN controller here, so the reserved pattern is exercised
    boot_mode_strap_selector #(.VARIANT(VAR_B), .HAS_CAN(1'b0)) uut_b (.clk_i(clk_i),
        .srst_i(srst_i), .init_done_i(init_done_i), .strap_pin_i(pin_b), .pullup_en_o(pu_b),
        .strap_seen_o(seen_b), .boot_valid_o(valid_b), .boot_sel_o(sel_b));
    boot_mode_strap_selector #(.VARIANT(VAR_C), .C_FLASH_ENTRY(CF), .C_RAM_ENTRY(CR),
        .C_OTP_ENTRY(CO), .C_EXT_ENTRY(CE)) uut_c (.clk_i(clk_i), .srst_i(srst_i),
        .init_done_i(init_done_i), .strap_pin_i(pin_c), .pullup_en_o(pu_c),
        .strap_seen_o(seen_c), .boot_valid_o(valid_c), .boot_sel_o(sel_c));

    task automatic complete_run;
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp4

    task automatic cmp_sel(input boot_sel_t got, input boot_sel_t exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_sel

    function automatic boot_sel_t mk(boot_action_t a, boot_source_t s, logic [21:0] ad);
        boot_sel_t r;
        r = '0;
        r.action = a;
        r.source = s;
        r.entry_addr = ad;
        r.loads_code = (a == ACT_LOAD);
        return r;
    endfunction : mk

    function automatic boot_sel_t exp_a(logic [3:0] p);
        if (p[3]) return mk(ACT_JUMP_FLASH, SRC_NONE, 22'h3F7FF6);
        if (p[2]) return mk(ACT_LOAD, SRC_SPI, 22'h0);
        case (p[1:0])
            2'h3: return mk(ACT_LOAD, SRC_UART, 22'h0);
            2'h2: return mk(ACT_JUMP_RAM, SRC_NONE, 22'h3F8000);
            2'h1: return mk(ACT_JUMP_OTP, SRC_NONE, 22'h3D7800);
            default: return mk(ACT_LOAD, SRC_PAR_GPIO, 22'h0);
        endcase
    endfunction : exp_a

    function automatic boot_sel_t exp_b(logic [2:0] p);
        boot_sel_t r;
        case (p)
            3'h7: r = mk(ACT_JUMP_FLASH, SRC_NONE, 22'h3F7FF6);
            3'h6: r = mk(ACT_LOAD, SRC_UART, 22'h0);
            3'h5: r = mk(ACT_LOAD, SRC_SPI, 22'h0);
            3'h4: r = mk(ACT_LOAD, SRC_I2C, 22'h0);
            3'h3: r = mk(ACT_LOAD, SRC_CAN, 22'h0);
            3'h2: r = mk(ACT_JUMP_RAM, SRC_NONE, 22'h000000);
            3'h1: r = mk(ACT_JUMP_OTP, SRC_NONE, 22'h3D7800);
            default: r = mk(ACT_LOAD, SRC_PAR_GPIO, 22'h0);
        endcase
        if (p == 3'h4) r.i2c_addr = 7'h50;
        if (p == 3'h3) r.can_mailbox = 5'h01;
        if (p == 3'h3) r.reserved_sel = 1'b1;
        return r;
    endfunction : exp_b

    function automatic boot_sel_t exp_c(logic [3:0] p);
        boot_sel_t r;
        case (p)
            4'hF: r = mk(ACT_JUMP_FLASH, SRC_NONE, CF);
            4'hE: r = mk(ACT_LOAD, SRC_UART, 22'h0);
            4'hD: r = mk(ACT_LOAD, SRC_SPI, 22'h0);
            4'hC: r = mk(ACT_LOAD, SRC_I2C, 22'h0);
            4'hB: r = mk(ACT_LOAD, SRC_CAN, 22'h0);
            4'hA: r = mk(ACT_LOAD, SRC_BSERIAL, 22'h0);
            4'h9, 4'h8: r = mk(ACT_JUMP_EXTBUS, SRC_NONE, CE);
            4'h7: r = mk(ACT_JUMP_OTP, SRC_NONE, CO);
            4'h6: r = mk(ACT_LOAD, SRC_PAR_GPIO, 22'h0);
            4'h5: r = mk(ACT_LOAD, SRC_PAR_EXTBUS, 22'h0);
            4'h4, 4'h1: r = mk(ACT_JUMP_RAM, SRC_NONE, CR);
            4'h3: r = mk(ACT_CHECK_MODE, SRC_NONE, 22'h0);
            4'h2: r = mk(ACT_JUMP_FLASH, SRC_NONE, CF);
            default: r = mk(ACT_LOAD, SRC_UART, 22'h0);
        endcase
        r.bus_x32 = (p == 4'h8);
        r.skip_calib = (p <= 4'h2);
        if (p == 4'hC) r.i2c_addr = 7'h50;
        if (p == 4'hB) r.can_mailbox = 5'h01;
        return r;
    endfunction : exp_c

    // reset, then count edges from release until variant A reports a decode, then check B and C are valid too
    task automatic boot(input logic [3:0] p, input logic [3:0] f);
        int n;
        n = 0;
        @(posedge clk_i);
        srst_i <= 1'b1;
        init_done_i <= 1'b0;
        lvl <= p;
        flt <= f;
        repeat (3) @(posedge clk_i);
        #1;
        cmp4({seen_a[0], seen_c[0], valid_b, valid_c}, 4'h0);
        cmp4(pu_a, 4'h8);
        cmp4(pu_b, 4'h0);
        cmp4(pu_c, 4'hF);
        @(posedge clk_i);
        srst_i <= 1'b0;
        init_done_i <= 1'b1;
        while (valid_a !== 1'b1 && n < 10)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        cmp4(4'(n), 4'h4);
        cmp4({valid_b, valid_c}, 4'h3);
    endtask : boot

    task automatic t_all_patterns;
        logic [3:0] p;
        for (int i = 0; i < 16; i++)
        begin
            p = 4'(i);
            boot(p, 4'h0);
            cmp_sel(sel_a, exp_a(p));
            cmp_sel(sel_b, exp_b(p[2:0]));
            cmp_sel(sel_c, exp_c(p));
            cmp4(seen_c, p);
            cmp4(seen_b & 4'h7, p & 4'h7);
            // shared pins move on after boot; the captured choice must not
            @(posedge clk_i);
            lvl <= ~p;
            init_done_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            #1;
            cmp_sel(sel_a, exp_a(p));
            cmp_sel(sel_b, exp_b(p[2:0]));
            cmp_sel(sel_c, exp_c(p));
            cmp4(seen_a, p);
        end
    endtask : t_all_patterns

    task automatic t_floating;
        boot(4'h0, 4'hF);
        cmp_sel(sel_a, exp_a(4'h8));
        cmp_sel(sel_c, exp_c(4'hF));
        cmp4(seen_c, 4'hF);
    endtask : t_floating

    initial
    begin
        repeat (10) @(posedge clk_i);
        t_all_patterns();
        t_floating();
        complete_run();
    end

    initial
    begin
        #100000;
        n_errors++;
        complete_run();
    end
endmodule : tb
